// ===== src/rge_pkg.sv
package rge_pkg;
  // Data and address widths of the register port, and the signed saturation width
  localparam int RGE_DW = 8;
  localparam int RGE_AW = 8;
  localparam int RGE_SAT_W = 18;
  // Bank select values
  localparam logic RGE_BANK0 = 1'b0;
  localparam logic RGE_BANK1 = 1'b1;
  // Bank 1 offsets
  localparam logic [RGE_AW-1:0] RGE_OFS_MID_TO_LOW = 8'h0C;
  localparam logic [RGE_AW-1:0] RGE_OFS_HIGH_TO_MID = 8'h0D;
  localparam logic [RGE_AW-1:0] RGE_OFS_LOW_TO_MID = 8'h0E;
  localparam logic [RGE_AW-1:0] RGE_OFS_MID_TO_HIGH = 8'h0F;
  localparam logic [RGE_AW-1:0] RGE_OFS_MID_ADD = 8'h10;
  localparam logic [RGE_AW-1:0] RGE_OFS_LOW_ADD = 8'h11;
  localparam logic [RGE_AW-1:0] RGE_OFS_SLOPE = 8'h13;
  // Bank 0 offsets
  localparam logic [RGE_AW-1:0] RGE_OFS_ENERGY = 8'h3A;
  localparam logic [RGE_AW-1:0] RGE_OFS_CORR = 8'h66;
  // Reset values
  localparam logic [RGE_DW-1:0] RGE_RST_THRESH = 8'h00;
  localparam logic [RGE_DW-1:0] RGE_RST_ADD = 8'h00;
  localparam logic [RGE_DW-1:0] RGE_RST_SLOPE = 8'h40;
  localparam logic [RGE_DW-1:0] RGE_RST_CORR = 8'h00;
  localparam logic [RGE_DW-1:0] RGE_RST_ZERO = 8'h00;
  // Slope is unsigned fixed point; 0x40 is a gain of one
  localparam int RGE_SLOPE_SHIFT = 6;
  localparam logic [RGE_DW-1:0] RGE_ENERGY_MIN = 8'h00;
  localparam logic [RGE_DW-1:0] RGE_ENERGY_MAX = 8'hFF;
  // Gain range of the receive chain
  typedef enum logic [2:0] {
    RGE_GAIN_HIGH = 3'b001,
    RGE_GAIN_MID = 3'b010,
    RGE_GAIN_LOW = 3'b100
  } rge_gain_e;
endpackage

// ===== src/rge_regbank.sv
`timescale 1ns/1ps
module rge_regbank
  import rge_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_bank,
  input wire logic [RGE_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [RGE_DW-1:0] reg_wdata,
  output logic [RGE_DW-1:0] reg_rdata,
  input wire logic [RGE_DW-1:0] energy_result,
  output logic [RGE_DW-1:0] high_to_mid_threshold,
  output logic [RGE_DW-1:0] mid_to_low_threshold,
  output logic [RGE_DW-1:0] mid_to_high_threshold,
  output logic [RGE_DW-1:0] low_to_mid_threshold,
  output logic [RGE_DW-1:0] mid_range_linearity_add,
  output logic [RGE_DW-1:0] low_range_linearity_add,
  output logic [RGE_DW-1:0] level_slope,
  output logic [RGE_DW-1:0] level_offset_correction
);

  // Address decode shared by the write and read paths
  function automatic logic hit(input logic b, input logic [RGE_AW-1:0] a,
                               input logic wb, input logic [RGE_AW-1:0] wa);
    hit = (b == wb) && (a == wa);
  endfunction

  // Configuration writes; status and unmapped writes are dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mid_to_low_threshold <= RGE_RST_THRESH;
      high_to_mid_threshold <= RGE_RST_THRESH;
      low_to_mid_threshold <= RGE_RST_THRESH;
      mid_to_high_threshold <= RGE_RST_THRESH;
      mid_range_linearity_add <= RGE_RST_ADD;
      low_range_linearity_add <= RGE_RST_ADD;
      level_slope <= RGE_RST_SLOPE;
      level_offset_correction <= RGE_RST_CORR;
    end else if (reg_wr) begin
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_MID_TO_LOW)) mid_to_low_threshold <= reg_wdata; // RL5
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_HIGH_TO_MID)) high_to_mid_threshold <= reg_wdata; // RL5
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_LOW_TO_MID)) low_to_mid_threshold <= reg_wdata; // RL5
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_MID_TO_HIGH)) mid_to_high_threshold <= reg_wdata; // RL5
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_MID_ADD)) mid_range_linearity_add <= reg_wdata; // RL6
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_LOW_ADD)) low_range_linearity_add <= reg_wdata; // RL6
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_SLOPE)) level_slope <= reg_wdata; // RL7
      if (hit(reg_bank, reg_addr, RGE_BANK0, RGE_OFS_CORR)) level_offset_correction <= reg_wdata; // RL8
    end
  end

  // Registered read data; unmapped offsets read as zero, held between reads
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= RGE_RST_ZERO;
    end else if (reg_rd) begin
      if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_MID_TO_LOW)) reg_rdata <= mid_to_low_threshold;
      else if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_HIGH_TO_MID)) reg_rdata <= high_to_mid_threshold;
      else if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_LOW_TO_MID)) reg_rdata <= low_to_mid_threshold;
      else if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_MID_TO_HIGH)) reg_rdata <= mid_to_high_threshold;
      else if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_MID_ADD)) reg_rdata <= mid_range_linearity_add;
      else if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_LOW_ADD)) reg_rdata <= low_range_linearity_add;
      else if (hit(reg_bank, reg_addr, RGE_BANK1, RGE_OFS_SLOPE)) reg_rdata <= level_slope;
      else if (hit(reg_bank, reg_addr, RGE_BANK0, RGE_OFS_CORR)) reg_rdata <= level_offset_correction;
      else if (hit(reg_bank, reg_addr, RGE_BANK0, RGE_OFS_ENERGY)) reg_rdata <= energy_result; // RL12
      else reg_rdata <= RGE_RST_ZERO;
    end
  end

endmodule

// ===== src/rge_energy_detect.sv
`timescale 1ns/1ps
// Summary of operation
// RL1 - In high range, RSSI above high-to-mid threshold moves to middle range.
// RL2 - In middle range, RSSI above mid-to-low threshold moves to low range.
// RL3 - In middle range, RSSI at or below mid-to-high threshold returns high.
// RL4 - In low range, RSSI at or below low-to-mid threshold returns middle.
// RL5 - Four gain thresholds live in bank 1 offsets 0x0C to 0x0F.
// RL6 - Middle and low range add values (bank 1, 0x10/0x11) keep reading continuous.
// RL7 - Slope at bank 1 offset 0x13 scales reading across 0x00 to 0xFF.
// RL8 - Correction at bank 0 offset 0x66 is added after slope scaling.
// RL9 - Positive correction keeps the energy value above 0x00.
// RL10 - Negative correction keeps the energy value below 0xFF.
// RL11 - Software sets thresholds, adds and slope once; only correction is tuned.
// RL12 - Energy result is readable at bank 0 offset 0x3A.
// RL13 - Result saturates to unsigned 8 bits; correction is two's complement.
// RL14 - Reset or receive start puts the gain machine in high range.
module rge_energy_detect
  import rge_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [RGE_DW-1:0] rssi,
  input wire logic rssi_valid,
  input wire logic rx_start,
  input wire logic reg_bank,
  input wire logic [RGE_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [RGE_DW-1:0] reg_wdata,
  output logic [RGE_DW-1:0] reg_rdata,
  output logic [2:0] gain_range,
  output logic [RGE_DW-1:0] energy_result,
  output logic energy_valid
);

  rge_gain_e gain_state;
  logic [RGE_DW-1:0] high_to_mid_threshold;
  logic [RGE_DW-1:0] mid_to_low_threshold;
  logic [RGE_DW-1:0] mid_to_high_threshold;
  logic [RGE_DW-1:0] low_to_mid_threshold;
  logic [RGE_DW-1:0] mid_range_linearity_add;
  logic [RGE_DW-1:0] low_range_linearity_add;
  logic [RGE_DW-1:0] level_slope;
  logic [RGE_DW-1:0] level_offset_correction;
  logic [RGE_DW-1:0] range_add;
  logic [RGE_DW:0] lin_level;
  logic lin_valid;
  logic [16:0] product;
  logic [16:0] scaled;
  logic [RGE_DW-1:0] scaled_sat;
  logic signed [RGE_SAT_W-1:0] corr_ext;
  logic signed [RGE_SAT_W-1:0] corr_sum;

  // Clamp a signed intermediate into the unsigned 8-bit result range
  function automatic logic [RGE_DW-1:0] sat8(input logic signed [RGE_SAT_W-1:0] v);
    logic signed [RGE_SAT_W-1:0] top;
    top = signed'({10'h000, RGE_ENERGY_MAX});
    if (v < 0) sat8 = RGE_ENERGY_MIN;
    else if (v > top) sat8 = RGE_ENERGY_MAX;
    else sat8 = v[RGE_DW-1:0];
  endfunction

  rge_regbank u_regs (
    .clk(clk),
    .nrst(nrst),
    .reg_bank(reg_bank),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .energy_result(energy_result),
    .high_to_mid_threshold(high_to_mid_threshold),
    .mid_to_low_threshold(mid_to_low_threshold),
    .mid_to_high_threshold(mid_to_high_threshold),
    .low_to_mid_threshold(low_to_mid_threshold),
    .mid_range_linearity_add(mid_range_linearity_add),
    .low_range_linearity_add(low_range_linearity_add),
    .level_slope(level_slope),
    .level_offset_correction(level_offset_correction)
  );

  // Gain range machine; receive start beats a sample in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_state <= RGE_GAIN_HIGH; // RL14
    end else if (rx_start) begin
      gain_state <= RGE_GAIN_HIGH; // RL14
    end else if (rssi_valid) begin
      case (gain_state)
        RGE_GAIN_HIGH: begin
          if (rssi > high_to_mid_threshold) gain_state <= RGE_GAIN_MID; // RL1
        end
        RGE_GAIN_MID: begin
          // Going down in gain is checked first so a strong burst is never clipped
          if (rssi > mid_to_low_threshold) gain_state <= RGE_GAIN_LOW; // RL2
          else if (rssi <= mid_to_high_threshold) gain_state <= RGE_GAIN_HIGH; // RL3
        end
        RGE_GAIN_LOW: begin
          if (rssi <= low_to_mid_threshold) gain_state <= RGE_GAIN_MID; // RL4
        end
        default: begin
          gain_state <= RGE_GAIN_HIGH;
        end
      endcase
    end
  end

  assign gain_range = gain_state;

  // Add value follows the range the sample was taken in
  always_comb begin
    case (gain_state)
      RGE_GAIN_MID: range_add = mid_range_linearity_add; // RL6
      RGE_GAIN_LOW: range_add = low_range_linearity_add; // RL6
      default: range_add = RGE_RST_ZERO;
    endcase
  end

  // First stage: linearised level, one bit wider so the add never wraps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lin_level <= 9'h000;
      lin_valid <= 1'b0;
    end else begin
      lin_valid <= rssi_valid;
      if (rssi_valid) lin_level <= {1'b0, rssi} + {1'b0, range_add}; // RL6
    end
  end

  // Slope scaling is saturated before the correction, so a positive correction
  // lifts the floor above zero and a negative one pulls the ceiling below full scale
  assign product = 17'(lin_level) * 17'(level_slope); // RL7
  assign scaled = product >> RGE_SLOPE_SHIFT; // RL7
  assign scaled_sat = sat8(signed'({1'b0, scaled})); // RL13
  assign corr_ext = {{10{level_offset_correction[RGE_DW-1]}}, level_offset_correction}; // RL13
  assign corr_sum = signed'({10'h000, scaled_sat}) + corr_ext; // RL8 RL9 RL10

  // Second stage: corrected result and its one-cycle valid pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      energy_result <= RGE_ENERGY_MIN;
      energy_valid <= 1'b0;
    end else begin
      energy_valid <= lin_valid;
      if (lin_valid) energy_result <= sat8(corr_sum); // RL13
    end
  end

  property p_high_to_mid;
    @(posedge clk) disable iff (!nrst)
    rssi_valid && !rx_start && gain_state == RGE_GAIN_HIGH && rssi > high_to_mid_threshold
      |=> gain_state == RGE_GAIN_MID;
  endproperty
  a_high_to_mid: assert property (p_high_to_mid) else $error("high range did not step to middle"); // RL1

  property p_mid_to_low;
    @(posedge clk) disable iff (!nrst)
    rssi_valid && !rx_start && gain_state == RGE_GAIN_MID && rssi > mid_to_low_threshold
      |=> gain_state == RGE_GAIN_LOW;
  endproperty
  a_mid_to_low: assert property (p_mid_to_low) else $error("middle range did not step to low"); // RL2

  property p_mid_to_high;
    @(posedge clk) disable iff (!nrst)
    rssi_valid && !rx_start && gain_state == RGE_GAIN_MID && !(rssi > mid_to_low_threshold)
      && rssi <= mid_to_high_threshold |=> gain_state == RGE_GAIN_HIGH;
  endproperty
  a_mid_to_high: assert property (p_mid_to_high) else $error("middle range did not return high"); // RL3

  property p_low_to_mid;
    @(posedge clk) disable iff (!nrst)
    rssi_valid && !rx_start && gain_state == RGE_GAIN_LOW && rssi <= low_to_mid_threshold
      |=> gain_state == RGE_GAIN_MID;
  endproperty
  a_low_to_mid: assert property (p_low_to_mid) else $error("low range did not return middle"); // RL4

  property p_start_high;
    @(posedge clk) disable iff (!nrst)
    rx_start ##1 !rx_start && !rssi_valid |-> gain_state == RGE_GAIN_HIGH ##1 gain_state == RGE_GAIN_HIGH;
  endproperty
  a_start_high: assert property (p_start_high) else $error("receive start did not select high range"); // RL14

  property p_pos_floor;
    @(posedge clk) disable iff (!nrst)
    lin_valid && !level_offset_correction[RGE_DW-1] && level_offset_correction != RGE_RST_ZERO
      |=> energy_valid && energy_result >= $past(level_offset_correction) && energy_result != RGE_ENERGY_MIN;
  endproperty
  a_pos_floor: assert property (p_pos_floor) else $error("positive correction let result reach zero"); // RL9

  property p_neg_ceiling;
    @(posedge clk) disable iff (!nrst)
    lin_valid && level_offset_correction[RGE_DW-1] |=> energy_valid && energy_result != RGE_ENERGY_MAX;
  endproperty
  a_neg_ceiling: assert property (p_neg_ceiling) else $error("negative correction let result reach full scale"); // RL10

  property p_status_read;
    @(posedge clk) disable iff (!nrst)
    reg_rd && reg_bank == RGE_BANK0 && reg_addr == RGE_OFS_ENERGY |=> reg_rdata == $past(energy_result);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read did not return energy result"); // RL12

  property p_start_wins;
    @(posedge clk) disable iff (!nrst)
    rx_start |=> gain_state == RGE_GAIN_HIGH;
  endproperty
  a_start_wins: assert property (p_start_wins) else $error("receive start lost to a sample"); // RL14

  property p_high_hold;
    @(posedge clk) disable iff (!nrst)
    rssi_valid && !rx_start && gain_state == RGE_GAIN_HIGH && rssi <= high_to_mid_threshold
      |=> gain_state == RGE_GAIN_HIGH;
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high range left without crossing threshold"); // RL1

  property p_low_hold;
    @(posedge clk) disable iff (!nrst)
    rssi_valid && !rx_start && gain_state == RGE_GAIN_LOW && rssi > low_to_mid_threshold
      |=> gain_state == RGE_GAIN_LOW;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low range left without crossing threshold"); // RL4

  property p_pipeline;
    @(posedge clk) disable iff (!nrst)
    rssi_valid |-> ##2 energy_valid;
  endproperty
  a_pipeline: assert property (p_pipeline) else $error("sample gave no result two cycles later"); // RL7

  property p_result_hold;
    @(posedge clk) disable iff (!nrst)
    !lin_valid |=> $stable(energy_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("energy result changed without a sample"); // RL12

  // A full-scale reading with no negative correction must stay at full scale, never wrap
  property p_sat_top;
    @(posedge clk) disable iff (!nrst)
    lin_valid && !level_offset_correction[RGE_DW-1] && scaled_sat == RGE_ENERGY_MAX
      |=> energy_result == RGE_ENERGY_MAX;
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("full-scale result wrapped"); // RL13

endmodule

// ===== tb/rge_rssi_source.sv
`timescale 1ns/1ps
// Behavioural stand-in for the analog receive chain that delivers digitised RSSI
module rge_rssi_source
  import rge_pkg::*;
(
  input wire logic clk,
  output logic [RGE_DW-1:0] rssi,
  output logic rssi_valid
);
  // Idle at time zero; the level bus carries no meaning until a sample is strobed
  initial begin
    rssi = 8'h00;
    rssi_valid = 1'b0;
  end
  // One sample per call; after the strobe the bus shows the inverse so stale data never looks valid
  task automatic send(input logic [RGE_DW-1:0] lvl);
    @(posedge clk);
    #1;
    rssi = lvl;
    rssi_valid = 1'b1;
    @(posedge clk);
    #1;
    rssi_valid = 1'b0;
    rssi = ~lvl;
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rge_pkg::*;
  logic clk;
  logic nrst;
  logic [RGE_DW-1:0] rssi;
  logic rssi_valid;
  logic rx_start;
  logic reg_bank;
  logic [RGE_AW-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [RGE_DW-1:0] reg_wdata;
  logic [RGE_DW-1:0] reg_rdata;
  logic [2:0] gain_range;
  logic [RGE_DW-1:0] energy_result;
  logic energy_valid;
  int bad_count;
  int num_checks;
  logic [31:0] seed;
  int m_range;
  int cfg [0:511];
  int adr [10] = '{9'h10C, 9'h10D, 9'h10E, 9'h10F, 9'h110, 9'h111, 9'h113, 9'h066, 9'h03A, 9'h112};
  logic [7:0] cv [7] = '{8'hC0, 8'h80, 8'hA0, 8'h60, 8'h28, 8'h50, 8'h48};
  logic [7:0] walk [6] = '{8'h80, 8'h81, 8'hC1, 8'hA0, 8'h81, 8'h60};
  logic [7:0] corr [5] = '{8'h00, 8'h30, 8'hD0, 8'h7F, 8'h80};

  rge_energy_detect u_dut (.clk(clk), .nrst(nrst), .rssi(rssi), .rssi_valid(rssi_valid), .rx_start(rx_start),
    .reg_bank(reg_bank), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .gain_range(gain_range), .energy_result(energy_result), .energy_valid(energy_valid));
  rge_rssi_source u_src (.clk(clk), .rssi(rssi), .rssi_valid(rssi_valid));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference: add for the range in force, slope with saturation, signed correction, clamp; then step the range
  function automatic int model(input int r);
    int sc;
    sc = ((r + (m_range == 1 ? cfg[9'h110] : m_range == 2 ? cfg[9'h111] : 0)) * cfg[9'h113]) >> 6;
    sc = (sc > 255 ? 255 : sc) + (cfg[9'h066] > 127 ? cfg[9'h066] - 256 : cfg[9'h066]);
    if (m_range == 0 && r > cfg[9'h10D]) m_range = 1;
    else if (m_range == 1 && r > cfg[9'h10C]) m_range = 2;
    else if (m_range == 1 && r <= cfg[9'h10F]) m_range = 0;
    else if (m_range == 2 && r <= cfg[9'h10E]) m_range = 1;
    return sc < 0 ? 0 : sc > 255 ? 255 : sc;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One register access; the status result place never takes writes
  task automatic reg_acc(input logic wr, input int a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_bank = a[8];
    reg_addr = a[7:0];
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (wr && a != 9'h03A) cfg[a] = d;
  endtask
  task automatic read_all();
    foreach (adr[i]) begin
      reg_acc(1'b0, adr[i], 8'h00);
      check(reg_rdata, 8'(cfg[adr[i]]));
    end
  endtask
  // Sample through the partner, wait a bounded time for the result, gap of zero to two cycles after
  task automatic sample(input logic [7:0] r);
    int e;
    int k;
    e = model(r);
    u_src.send(r);
    k = 0;
    while (energy_valid !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    check({7'h00, energy_valid}, 8'h01);
    check(energy_result, 8'(e));
    check({5'h00, gain_range}, 8'(1 << m_range));
    cfg[9'h03A] = e;
    repeat (xs() % 3) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog well beyond the roughly one thousand cycles the sequence needs
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    rx_start = 1'b0;
    reg_bank = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    seed = 32'h52AB7DB2;
    m_range = 0;
    foreach (cfg[i]) cfg[i] = 0;
    cfg[9'h113] = 8'h40;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    check({5'h00, gain_range}, 8'h01);
    read_all();
    // Static setup is written once; only the correction is retuned below
    for (int i = 0; i < 7; i++) reg_acc(1'b1, adr[i], cv[i]);
    reg_acc(1'b1, 9'h03A, 8'h55);
    foreach (walk[i]) sample(walk[i]);
    sample(8'h90);
    @(posedge clk);
    #1;
    rx_start = 1'b1;
    @(posedge clk);
    #1;
    rx_start = 1'b0;
    m_range = 0;
    check({5'h00, gain_range}, 8'h01);
    // Start and a strong sample in one cycle: start wins, the sample still gives a result
    cfg[9'h03A] = model(8'hFF);
    m_range = 0;
    fork
      u_src.send(8'hFF);
      begin
        @(posedge clk);
        #1;
        rx_start = 1'b1;
        @(posedge clk);
        #1;
        rx_start = 1'b0;
      end
    join
    @(posedge clk);
    #1;
    check({7'h00, energy_valid}, 8'h01);
    check(energy_result, 8'(cfg[9'h03A]));
    check({5'h00, gain_range}, 8'h01);
    foreach (corr[c]) begin
      reg_acc(1'b1, 9'h066, corr[c]);
      repeat (40) sample(8'(xs()));
      sample(8'h00);
      sample(8'hFF);
    end
    read_all();
    finish_test();
  end
endmodule
